/* dv/uab_core_assertions.sv */
// Port assertions for the autobaud and wake block
`timescale 1ns/1ps
module uab_core_chk #(parameter DIV_W = 16) (
   // Clock and reset
   input wire clk_sys,
   input wire clk_en,
   input wire arst_n,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Line and status
   input wire receive_pin,
   input wire sleep_mode,
   input wire [7:0] rx_data,
   input wire receive_flag,
   input wire receiver_idle_flag,
   input wire wake_event
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer");
   chk_rxbuf_value: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata == $past(rx_data))
      else $error("buffer read value");
   chk_flag_holds: assert property (receive_flag && !(reg_rd && reg_addr == 4'h3) |=> receive_flag)
      else $error("flag dropped");
   chk_flag_wake: assert property ($rose(receive_flag) && !receive_pin |-> ##[0:1] wake_event)
      else $error("flag without wake");
   chk_wake_flag: assert property (wake_event |-> ##[0:1] receive_flag)
      else $error("wake without flag");
   chk_wake_pulse: assert property (wake_event |=> !wake_event)
      else $error("wake pulse long");
   chk_wake_low: assert property (wake_event |-> !receive_pin && !receiver_idle_flag)
      else $error("wake on high line");
   chk_sync_idle: assert property ($rose(receive_flag) && receive_pin |-> ##[0:2] receiver_idle_flag)
      else $error("not idle after sync");
endmodule
bind uab_core uab_core_chk #(.DIV_W(DIV_W)) uab_core_chk_inst (.*);

/* dv/uab_core_test.sv */
// Self-checking bench for the autobaud and wake block
`timescale 1ns/1ps
module uab_core_test;
   logic clk_sys = 0;
   logic arst_n = 0;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic sleep_mode = 0;
   logic clk_en = 1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic receive_pin, receive_flag, receiver_idle_flag, wake_event;
   int failures = 0;
   int comparisons = 0;
   int wake_count = 0;
   always #5 clk_sys = ~clk_sys;
   // Count wake pulses seen by the bench
   always @(posedge clk_sys) begin
      if (wake_event === 1'b1) begin
         wake_count++;
      end
   end
   uab_core uab_core_inst (.clk_sys(clk_sys), .clk_en(clk_en), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .receive_pin(receive_pin), .sleep_mode(sleep_mode), .rx_data(8'h5a), .receive_flag(receive_flag),
      .receiver_idle_flag(receiver_idle_flag), .wake_event(wake_event));
   uab_remote_node uab_remote_node_inst (.clk_sys(clk_sys), .line(receive_pin));
   task automatic wr(input [3:0] a, input [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input [3:0] a, input [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      comparisons++;
      if (reg_rdata !== e) begin
         failures++;
         $display("MISMATCH reg %h exp %h got %h", a, e, reg_rdata);
      end
   endtask
   // Called only after rd, so outputs have settled
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic print_verdict;
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic t_reset;
      rd(4'h0, 8'h00);
      rd(4'h2, 8'h00);
      rd(4'h4, 8'h02);
      rd(4'h9, 8'h00);
   endtask
   // Every select pair gives the same count
   task automatic t_autobaud(input [7:0] m, input int bt);
      wr(4'h0, m);
      uab_remote_node_inst.send(8'h55, bt);
      rd(4'h0, m & 8'hfe);
      chk("receive_flag", 8'h01, receive_flag);
      rd(4'h1, 8'h11);
      rd(4'h2, 8'h00);
      rd(4'h4, 8'h03);
      rd(4'h3, 8'h5a);
      chk("receive_flag", 8'h00, receive_flag);
      chk("receiver_idle_flag", 8'h01, receiver_idle_flag);
      rd(4'h4, 8'h02);
   endtask
   task automatic t_wake;
      wr(4'h0, 8'h1d);
      sleep_mode <= 1'b1;
      uab_remote_node_inst.brk(64);
      rd(4'h4, 8'h05);
      chk("receive_flag", 8'h01, receive_flag);
      chk("receiver_idle_flag", 8'h00, receiver_idle_flag);
      uab_remote_node_inst.drive(1'b1, 64);
      sleep_mode <= 1'b0;
      rd(4'h0, 8'h19);
      rd(4'h3, 8'h5a);
      uab_remote_node_inst.send(8'h55, 64);
      rd(4'h0, 8'h18);
      rd(4'h1, 8'h11);
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h5a);
      chk("wake_count", 8'h01, wake_count[7:0]);
   endtask
   task automatic t_sync;
      wr(4'h0, 8'h24);
      rd(4'h0, 8'h20);
   endtask
   // Overflow set by software sticks until enable drops
   task automatic t_abort;
      wr(4'h0, 8'h03);
      rd(4'h0, 8'h03);
      wr(4'h0, 8'h01);
      rd(4'h0, 8'h03);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
   endtask
   // A write while the clock enable is low is lost
   task automatic t_freeze;
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(4'h0, 8'h08);
      clk_en <= 1'b1;
      rd(4'h0, 8'h00);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_autobaud(8'h19, 64);
      t_autobaud(8'h09, 256);
      t_autobaud(8'h11, 256);
      t_autobaud(8'h01, 1024);
      t_wake();
      t_sync();
      t_abort();
      t_freeze();
      print_verdict();
   end
   // Whole run needs about 20000 cycles
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end
endmodule

/* dv/uab_remote_node.sv */
// Remote serial node driving the receive line
`timescale 1ns/1ps
module uab_remote_node (
   // Clock and line
   input wire clk_sys,
   output logic line
);
   initial line = 1'b1;
   task automatic drive(input logic v, input int n);
      line <= v;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic send(input [7:0] b, input int bt);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         drive(f[i], bt);
      end
   endtask
   task automatic brk(input int bt);
      drive(1'b0, bt * 13);
   endtask
endmodule

/* hw/uab_core.v */
// Autobaud measurement and wake-on-break logic of an asynchronous receiver
//
// Functional notes
// - Autobaud enable starts calibration, receiver idle
// - Count from first rise after start
// - Fifth rise: keep count, clear enable, flag
// - Receive buffer read clears receive flag
// - Base clock osc/4, /16, /64 by selects
// - Divisor counts at base clock over eight
// - Divisor pair one 16-bit counter
// - Counter starts at one
// - Overflow flags, counting continues to end
// - Overflow clears only with enable clear
// - Wake plus autobaud: measure next character
// - Sleep stops rate generator and reception
// - Wake only in asynchronous mode
// - Wake enable idles receiver, watches falling
// - Falling edge sets flag, also in sleep
// - Rising edge ends break, clears wake
// - Non-zero character low time wakes
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "uab_defines.vh"
module uab_core #(
   parameter DIV_W = 16
) (
   // Clock, enable, reset
   input wire clk_sys,
   input wire clk_en,
   input wire arst_n,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Line and power state
   input wire receive_pin,
   input wire sleep_mode,
   input wire [7:0] rx_data,
   // Status out
   output reg receive_flag,
   output reg receiver_idle_flag,
   output reg wake_event
);
   wire rx_line;
   reg rx_prev_r;
   wire awake_line;
   wire sleep_sync;
   reg [7:0] ctrl_r;
   reg [DIV_W-1:0] div_r;
   reg [15:0] pre_cnt_r;
   reg [2:0] edges_r;
   reg [1:0] ab_state_r;
   reg rx_flag_r;
   reg low_seen_r;
   reg [7:0] ctrl_nxt;
   reg [DIV_W-1:0] div_nxt;
   reg [1:0] ab_state_nxt;
   reg [2:0] edges_nxt;
   reg [15:0] pre_nxt;
   reg flag_set;
   reg [DIV_W:0] div_inc;

   localparam AB_IDLE = 2'b00;
   localparam AB_START = 2'b01;
   localparam AB_COUNT = 2'b10;

   // =============================================
   // Address decode
   function reg_hit;
      input [3:0] addr;
      input [3:0] ofs;
      begin
         reg_hit = (addr == ofs);
      end
   endfunction

   wire ab_en = ctrl_r[`UAB_CTL_AB_EN];
   wire wake_en = ctrl_r[`UAB_CTL_WAKE_EN];
   wire rx_rise = rx_line & ~rx_prev_r;
   wire rx_fall = ~rx_line & rx_prev_r;
   wire wr_ctrl = reg_wr && reg_hit(reg_addr, `UAB_OFS_CTRL);
   wire rd_buf = reg_rd && reg_hit(reg_addr, `UAB_OFS_RXBUF);
   // Divisor frozen while calibrating, or the count breaks
   wire wr_div_lo = reg_wr && !ab_en && reg_hit(reg_addr, `UAB_OFS_DIV_LO);
   wire wr_div_hi = reg_wr && !ab_en && reg_hit(reg_addr, `UAB_OFS_DIV_HI);
   wire [7:0] status_byte = {5'h00, sleep_sync, receiver_idle_flag, rx_flag_r};

   // =============================================
   // Rate selection
   // base clock divide select
   function [15:0] base_div;
      input wide;
      input hspd;
      begin
         if (wide && hspd) begin
            base_div = `UAB_PRE_FAST;
         end else if (wide || hspd) begin
            base_div = `UAB_PRE_MID;
         end else begin
            base_div = `UAB_PRE_SLOW;
         end
      end
   endfunction

   // autobaud tick at base over eight
   wire [31:0] ab_product = base_div(ctrl_r[`UAB_CTL_WIDE], ctrl_r[`UAB_CTL_HSPD]) * `UAB_AB_SLOW;
   wire [15:0] ab_period = ab_product[15:0];
   wire ab_tick = (pre_cnt_r == ab_period - 16'h0001);

   uab_rx_sync u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .line_in(receive_pin),
      .line_out(rx_line)
   );

   // Sleep passes the same filter; inverted so reset reads awake
   uab_rx_sync u_sleep_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .line_in(~sleep_mode),
      .line_out(awake_line)
   );
   assign sleep_sync = ~awake_line;

   // =============================================
   // Next state
   always @* begin
      ctrl_nxt = ctrl_r;
      div_nxt = div_r;
      ab_state_nxt = ab_state_r;
      edges_nxt = edges_r;
      pre_nxt = pre_cnt_r;
      flag_set = 1'b0;
      div_inc = {1'b0, div_r} + {{DIV_W{1'b0}}, 1'b1};
      // Software control writes
      if (wr_ctrl) begin
         ctrl_nxt = reg_wdata;
         if (ab_en && reg_wdata[`UAB_CTL_AB_EN]) begin
            ctrl_nxt[`UAB_CTL_AB_OVF] = ctrl_r[`UAB_CTL_AB_OVF] | reg_wdata[`UAB_CTL_AB_OVF];
         end
         if (reg_wdata[`UAB_CTL_SYNC]) begin
            ctrl_nxt[`UAB_CTL_WAKE_EN] = 1'b0;
         end
      end
      if (wake_en) begin
         ab_state_nxt = AB_IDLE;
         pre_nxt = 16'h0000;
         if (rx_fall) begin
            flag_set = 1'b1;
         end
         if (rx_rise && low_seen_r) begin
            ctrl_nxt[`UAB_CTL_WAKE_EN] = 1'b0;
         end
      end else if (ab_en && !sleep_sync) begin
         case (ab_state_r)
            AB_IDLE: begin
               if (rx_fall) begin
                  ab_state_nxt = AB_START;
               end
            end
            AB_START: begin
               if (rx_rise) begin
                  ab_state_nxt = AB_COUNT;
                  div_nxt = {{(DIV_W-1){1'b0}}, 1'b1};
                  edges_nxt = 3'h1;
                  pre_nxt = 16'h0000;
               end
            end
            AB_COUNT: begin
               pre_nxt = ab_tick ? 16'h0000 : pre_cnt_r + 16'h0001;
               if (ab_tick) begin
                  div_nxt = div_inc[DIV_W-1:0];
                  if (div_inc[DIV_W]) begin
                     ctrl_nxt[`UAB_CTL_AB_OVF] = 1'b1;
                  end
               end
               if (rx_rise) begin
                  edges_nxt = edges_r + 3'h1;
                  if (edges_r + 3'h1 == `UAB_SYNC_EDGES) begin
                     // A tick on this edge still counts: result is ticks plus one
                     ctrl_nxt[`UAB_CTL_AB_EN] = 1'b0;
                     flag_set = 1'b1;
                     ab_state_nxt = AB_IDLE;
                  end
               end
            end
            default: begin
               ab_state_nxt = AB_IDLE;
            end
         endcase
      end else begin
         ab_state_nxt = AB_IDLE;
         pre_nxt = 16'h0000;
      end
      // Divisor writable when not calibrating
      if (wr_div_lo) begin
         div_nxt[7:0] = reg_wdata;
      end
      if (wr_div_hi) begin
         div_nxt[DIV_W-1:8] = reg_wdata[DIV_W-9:0];
      end
   end

   // =============================================
   // Line edge tracking
   // Previous level resets high, so idle gives no false edge
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_prev_r <= 1'b1;
         low_seen_r <= 1'b0;
      end else if (clk_en) begin
         rx_prev_r <= rx_line;
         // Break low seen before the closing rise
         // Stray rise before any fall must not end the wake
         low_seen_r <= wake_en & ~rx_line & (low_seen_r | rx_fall);
      end
   end

   // =============================================
   // State registers
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `UAB_CTRL_RST;
         div_r <= `UAB_DIV_RST;
         pre_cnt_r <= 16'h0000;
         edges_r <= 3'h0;
         ab_state_r <= AB_IDLE;
      end else if (clk_en) begin
         ctrl_r <= ctrl_nxt;
         div_r <= div_nxt;
         pre_cnt_r <= pre_nxt;
         edges_r <= edges_nxt;
         ab_state_r <= ab_state_nxt;
      end
   end

   // =============================================
   // Flags and status outputs
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_flag_r <= 1'b0;
         receive_flag <= 1'b0;
         receiver_idle_flag <= 1'b1;
         wake_event <= 1'b0;
      end else if (clk_en) begin
         // read clears, set wins
         // A read racing a new event must not lose it
         if (flag_set) begin
            rx_flag_r <= 1'b1;
            receive_flag <= 1'b1;
         end else if (rd_buf) begin
            rx_flag_r <= 1'b0;
            receive_flag <= 1'b0;
         end
         receiver_idle_flag <= (ab_state_nxt == AB_IDLE) && !(wake_en && !rx_line);
         wake_event <= wake_en & rx_fall;
      end
   end

   // =============================================
   // Register read port
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         // Data stand for one cycle, zero otherwise
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `UAB_OFS_CTRL: reg_rdata <= ctrl_r;
               `UAB_OFS_DIV_LO: reg_rdata <= div_r[7:0];
               // Top byte only; a wider counter is not readable
               `UAB_OFS_DIV_HI: reg_rdata <= div_r[DIV_W-1:DIV_W-8];
               `UAB_OFS_RXBUF: reg_rdata <= rx_data;
               `UAB_OFS_STAT: reg_rdata <= status_byte;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule

/* hw/uab_defines.vh */
// Register map, field positions, reset values and rate constants for the autobaud/wake block
`ifndef UAB_DEFINES_VH
`define UAB_DEFINES_VH
// Register offsets
`define UAB_OFS_CTRL 4'h0
`define UAB_OFS_DIV_LO 4'h1
`define UAB_OFS_DIV_HI 4'h2
`define UAB_OFS_RXBUF 4'h3
`define UAB_OFS_STAT 4'h4
// Control register fields
`define UAB_CTL_AB_EN 0
`define UAB_CTL_AB_OVF 1
`define UAB_CTL_WAKE_EN 2
`define UAB_CTL_WIDE 3
`define UAB_CTL_HSPD 4
`define UAB_CTL_SYNC 5
// Status register fields
`define UAB_ST_RXFLAG 0
`define UAB_ST_RXIDLE 1
`define UAB_ST_SLEEP 2
// Reset values
`define UAB_CTRL_RST 8'h00
`define UAB_DIV_RST 16'h0000
// Base clock prescales and autobaud slowdown
`define UAB_PRE_FAST 16'h0004
`define UAB_PRE_MID 16'h0010
`define UAB_PRE_SLOW 16'h0040
`define UAB_AB_SLOW 16'h0008
// Rising edges in a sync character
`define UAB_SYNC_EDGES 3'h5
`endif

/* hw/uab_rx_sync.v */
// Three-stage synchroniser with agreement filter for the receive line
`timescale 1ns/1ps
module uab_rx_sync (
   // Clock and reset
   input wire clk_sys,
   input wire arst_n,
   input wire clk_en,
   // Line in, filtered level out
   input wire line_in,
   output reg line_out
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   // =============================================
   // Synchroniser
   // three-stage line sync
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         line_out <= 1'b1;
      end else if (clk_en) begin
         s1_r <= line_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // Change only once two late stages agree
         if (s2_r == s3_r) begin
            line_out <= s3_r;
         end
      end
   end
endmodule
